/* rtl/ccm_top.sv */
/*
 * calibration check mode controller: zero and span check modes from two
 * active-low pins or multidrop serial commands, pump and valve drive,
 * display mode code, periodic reference shutter, apb register slave.
 * assumes CLK at 250 MHz, pins asynchronous to it, an apb master on CLK.
 */
// Local design decisions: register access over APB and the placing of the registers.
//
// Notes on behaviour
// - zero pin low enters zero mode: sample pump off, zero pump on
// - zero mode holds while pin low; release restores sample pump
// - span pin low enters span mode: sample pump off, span valve open
// - span mode holds while pin low; release closes valve, sample pump on
// - check modes never change calibration; coefficient writes are locked out
// - display shows a zero or span message code during check modes
// - serial command channel 0 state 1 enters span, state 0 leaves it
// - serial command channel 1 state 1 enters zero, state 0 leaves it
// - module address resets to zero and software may change it
// - service port takes no multidrop commands, only counts bytes
// - serial port defaults to 9600 baud, 8N1, divisor writable
// - reference shutter inserted automatically every 30 seconds
// - mode pins act always, with no enable setting
`timescale 1ns/1ps

`include "ccm_regs.svh"

module ccm_top #(
    parameter logic [19:0] DEBOUNCE_CYC = 20'(`CCM_DEBOUNCE_US * (`CCM_CLK_HZ / 1000000)),
    parameter logic [35:0] REF_PERIOD_CYC = 36'(`CCM_REF_PERIOD_S) * 36'(`CCM_CLK_HZ),
    parameter logic [35:0] REF_HOLD_CYC = 36'(`CCM_REF_HOLD_MS) * 36'(`CCM_CLK_HZ / 1000)
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        ZERO_CHECK_INPUT_N,
    input  wire logic        SPAN_CHECK_INPUT_N,
    input  wire logic        MD_RXD,
    output logic             MD_TXD,
    input  wire logic        SVC_RXD,
    output logic             SVC_TXD,
    output logic             SAMPLE_PUMP,
    output logic             ZERO_PUMP,
    output logic             SPAN_VALVE,
    output logic             SHUTTER,
    output logic      [1:0]  DISP_MSG,
    output logic             CAL_LOCK
);

    localparam logic [15:0] BAUD_RESET = 16'(`CCM_CLK_HZ / `CCM_BAUD_DEFAULT);

    logic [1:0]             rst_sync;
    logic                   rst_n;
    logic [1:0]             pin_meta;
    logic [1:0]             pin_sync;
    logic [1:0]             pin_stable;
    logic [19:0]            deb_cnt [2];
    logic [1:0]             md_rx_sync;
    logic [1:0]             svc_rx_sync;
    logic [7:0]             module_addr;
    logic [15:0]            baud_div;
    logic [15:0]            svc_count;
    logic [7:0]             md_byte;
    logic                   md_valid;
    logic [7:0]             svc_byte;
    logic                   svc_valid;
    logic                   md_tx_busy;
    logic                   md_tx_start;
    logic [7:0]             md_tx_data;
    ccm_pkg::ccm_parse_type parse;
    logic [3:0]             field [4];
    logic [1:0]             field_idx;
    logic                   ser_zero;
    logic                   ser_span;
    logic [1:0]             reply_left;
    ccm_pkg::ccm_mode_type  mode;
    ccm_pkg::ccm_mode_type  next_mode;
    ccm_pkg::ccm_act_type   act;
    logic [35:0]            ref_cnt;
    logic                   zero_req;
    logic                   span_req;
    logic [7:0]             cmd_addr;
    logic                   cmd_match;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `CCM_OFS_ADDR) || (a == `CCM_OFS_BAUD) ||
                  (a == `CCM_OFS_STATUS) || (a == `CCM_OFS_SVC_CNT);
    endfunction

    function automatic logic is_digit(input logic [7:0] b);
        is_digit = (b >= `CCM_CHAR_0) && (b <= `CCM_CHAR_9);
    endfunction

    // ------------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta    <= 2'b00;
            pin_sync    <= 2'b00;
            md_rx_sync  <= 2'b11;
            svc_rx_sync <= 2'b11;
        end else begin
            pin_meta    <= {~SPAN_CHECK_INPUT_N, ~ZERO_CHECK_INPUT_N};
            pin_sync    <= pin_meta;
            md_rx_sync  <= {md_rx_sync[0], MD_RXD};
            svc_rx_sync <= {svc_rx_sync[0], SVC_RXD};
        end
    end

    // ------------------------------------------------------------------------
    // debounce: bit 0 zero check, bit 1 span check, both always enabled
    // ------------------------------------------------------------------------
    generate
        for (genvar i = 0; i < 2; i++) begin : g_deb
            always_ff @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    deb_cnt[i]    <= 20'h00000;
                    pin_stable[i] <= 1'b0;
                end else if (pin_sync[i] == pin_stable[i]) begin
                    deb_cnt[i] <= 20'h00000;
                end else if (deb_cnt[i] >= DEBOUNCE_CYC - 20'h00001) begin
                    deb_cnt[i]    <= 20'h00000;
                    pin_stable[i] <= pin_sync[i];
                end else begin
                    deb_cnt[i] <= deb_cnt[i] + 20'h00001;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // serial ports
    // ------------------------------------------------------------------------
    ccm_uart u_md_uart (
        .clk      (CLK),
        .rst_n    (rst_n),
        .divisor  (baud_div),
        .rx       (md_rx_sync[1]),
        .rx_data  (md_byte),
        .rx_valid (md_valid),
        .tx_data  (md_tx_data),
        .tx_start (md_tx_start),
        .tx_busy  (md_tx_busy),
        .tx       (MD_TXD)
    );

    // service port bytes only counted; the unpolled transmitter stays idle
    ccm_uart u_svc_uart (
        .clk      (CLK),
        .rst_n    (rst_n),
        .divisor  (baud_div),
        .rx       (svc_rx_sync[1]),
        .rx_data  (svc_byte),
        .rx_valid (svc_valid),
        .tx_data  (svc_byte),
        .tx_start (1'b0),
        .tx_busy  (),
        .tx       (SVC_TXD)
    );

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            svc_count <= 16'h0000;
        end else if (svc_valid) begin
            svc_count <= svc_count + 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // multidrop command parser: D O a a c s CR
    // ------------------------------------------------------------------------
    assign cmd_addr  = ({4'h0, field[0]} * 8'h0A) + {4'h0, field[1]};
    assign cmd_match = (cmd_addr == module_addr);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            parse     <= ccm_pkg::CCM_P_D;
            field_idx <= 2'b00;
            for (int k = 0; k < 4; k++) begin
                field[k] <= 4'h0;
            end
        end else if (md_valid) begin
            case (parse)
                ccm_pkg::CCM_P_D: begin
                    if (md_byte == `CCM_CHAR_D) begin
                        parse <= ccm_pkg::CCM_P_O;
                    end
                end
                ccm_pkg::CCM_P_O: begin
                    parse     <= (md_byte == `CCM_CHAR_O) ? ccm_pkg::CCM_P_FIELD : ccm_pkg::CCM_P_D;
                    field_idx <= 2'b00;
                end
                ccm_pkg::CCM_P_FIELD: begin
                    if (is_digit(md_byte)) begin
                        field[field_idx] <= md_byte[3:0];
                        field_idx        <= field_idx + 2'b01;
                        if (field_idx == 2'b11) begin
                            parse <= ccm_pkg::CCM_P_CR;
                        end
                    end else begin
                        parse <= ccm_pkg::CCM_P_D;
                    end
                end
                ccm_pkg::CCM_P_CR: begin
                    parse <= ccm_pkg::CCM_P_D;
                end
                default: begin
                    parse <= ccm_pkg::CCM_P_D;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // serial mode requests and reply
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ser_zero   <= 1'b0;
            ser_span   <= 1'b0;
            reply_left <= 2'b00;
        end else begin
            if (md_valid && parse == ccm_pkg::CCM_P_CR && md_byte == `CCM_CHAR_CR && cmd_match) begin
                if (field[2] == `CCM_CHAN_SPAN && field[3] <= 4'h1) begin
                    ser_span   <= field[3][0];
                    reply_left <= 2'b10;
                end else if (field[2] == `CCM_CHAN_ZERO && field[3] <= 4'h1) begin
                    ser_zero   <= field[3][0];
                    reply_left <= 2'b10;
                end
            end else if (md_tx_start) begin
                reply_left <= reply_left - 2'b01;
            end
        end
    end

    assign md_tx_start = (reply_left != 2'b00) && !md_tx_busy;
    assign md_tx_data  = (reply_left == 2'b10) ? `CCM_CHAR_ACK : `CCM_CHAR_CR;

    // ------------------------------------------------------------------------
    // measure mode: zero has priority over span
    // ------------------------------------------------------------------------
    assign zero_req = pin_stable[0] || ser_zero;
    assign span_req = pin_stable[1] || ser_span;

    always_comb begin
        if (zero_req) begin
            next_mode = ccm_pkg::CCM_ZERO;
        end else if (span_req) begin
            next_mode = ccm_pkg::CCM_SPAN;
        end else begin
            next_mode = ccm_pkg::CCM_SAMPLE;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode <= ccm_pkg::CCM_SAMPLE;
        end else begin
            mode <= next_mode;
        end
    end

    always_comb begin
        case (mode)
            ccm_pkg::CCM_ZERO: begin
                act = '{sample_pump: 1'b0, zero_pump: 1'b1, span_valve: 1'b0};
            end
            ccm_pkg::CCM_SPAN: begin
                act = '{sample_pump: 1'b0, zero_pump: 1'b0, span_valve: 1'b1};
            end
            default: begin
                act = '{sample_pump: 1'b1, zero_pump: 1'b0, span_valve: 1'b0};
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SAMPLE_PUMP <= 1'b1;
            ZERO_PUMP   <= 1'b0;
            SPAN_VALVE  <= 1'b0;
            DISP_MSG    <= 2'b00;
            CAL_LOCK    <= 1'b0;
        end else begin
            SAMPLE_PUMP <= act.sample_pump;
            ZERO_PUMP   <= act.zero_pump;
            SPAN_VALVE  <= act.span_valve;
            DISP_MSG    <= {mode == ccm_pkg::CCM_SPAN, mode == ccm_pkg::CCM_ZERO};
            CAL_LOCK    <= (mode != ccm_pkg::CCM_SAMPLE);
        end
    end

    // ------------------------------------------------------------------------
    // reference shutter
    // ------------------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt <= 36'h000000000;
            SHUTTER <= 1'b0;
        end else begin
            if (ref_cnt >= REF_PERIOD_CYC - 36'h000000001) begin
                ref_cnt <= 36'h000000000;
            end else begin
                ref_cnt <= ref_cnt + 36'h000000001;
            end
            SHUTTER <= (ref_cnt < REF_HOLD_CYC);
        end
    end

    // ------------------------------------------------------------------------
    // apb slave: zero wait states, error on unmapped address
    // ------------------------------------------------------------------------
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !reg_hit(PADDR);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            module_addr <= `CCM_ADDR_RESET;
            baud_div    <= BAUD_RESET;
        end else if (PSEL && PENABLE && PWRITE) begin
            if (PADDR == `CCM_OFS_ADDR && PWDATA[7:0] <= `CCM_ADDR_MAX) begin
                module_addr <= PWDATA[7:0];
            end
            if (PADDR == `CCM_OFS_BAUD && PWDATA[15:0] != 16'h0000) begin
                baud_div <= PWDATA[15:0];
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                `CCM_OFS_ADDR:    PRDATA <= {24'h000000, module_addr};
                `CCM_OFS_BAUD:    PRDATA <= {16'h0000, baud_div};
                `CCM_OFS_STATUS:  PRDATA <= {23'h000000, SHUTTER, ser_span, ser_zero, pin_stable, mode, CAL_LOCK};
                `CCM_OFS_SVC_CNT: PRDATA <= {16'h0000, svc_count};
                default:          PRDATA <= 32'h00000000;
            endcase
        end
    end

endmodule

/* rtl/ccm_regs.svh */
/*
 * register offsets, reset values, timing figures and command characters of
 * the calibration check mode controller.
 * assumes byte addresses on a 32-bit apb bus, one word per register.
 */
`ifndef CCM_REGS_SVH
`define CCM_REGS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define CCM_OFS_ADDR      8'h00
`define CCM_OFS_BAUD      8'h04
`define CCM_OFS_STATUS    8'h08
`define CCM_OFS_SVC_CNT   8'h0C
`define CCM_ADDR_RESET    8'h00
`define CCM_ADDR_MAX      8'h63

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CCM_CLK_HZ        250000000
`define CCM_BAUD_DEFAULT  9600
`define CCM_DEBOUNCE_US   1000
`define CCM_REF_PERIOD_S  30
`define CCM_REF_HOLD_MS   1000

// ----------------------------------------------------------------------------
// command characters
// ----------------------------------------------------------------------------
`define CCM_CHAR_D        8'h44
`define CCM_CHAR_O        8'h4F
`define CCM_CHAR_CR       8'h0D
`define CCM_CHAR_0        8'h30
`define CCM_CHAR_9        8'h39
`define CCM_CHAR_ACK      8'h06
`define CCM_CHAN_SPAN     4'h0
`define CCM_CHAN_ZERO     4'h1

`endif

/* rtl/ccm_pkg.sv */
/*
 * types shared by the calibration check mode controller.
 * assumes nothing beyond a systemverilog compiler.
 */
package ccm_pkg;

    typedef enum logic [2:0] {
        CCM_SAMPLE = 3'b001,
        CCM_ZERO   = 3'b010,
        CCM_SPAN   = 3'b100
    } ccm_mode_type;

    typedef enum logic [3:0] {
        CCM_P_D     = 4'b0001,
        CCM_P_O     = 4'b0010,
        CCM_P_FIELD = 4'b0100,
        CCM_P_CR    = 4'b1000
    } ccm_parse_type;

    typedef struct packed {
        logic sample_pump;
        logic zero_pump;
        logic span_valve;
    } ccm_act_type;

endpackage

/* rtl/ccm_uart.sv */
/*
 * 8 data bits, no parity, one stop bit serial transceiver.
 * assumes rx is already synchronised to clk; divisor is clocks per bit.
 */
`timescale 1ns/1ps

module ccm_uart (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] divisor,
    input  wire logic        rx,
    output logic      [7:0]  rx_data,
    output logic             rx_valid,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_start,
    output logic             tx_busy,
    output logic             tx
);

    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic        rx_busy;
    logic [7:0]  rx_sh;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;

    // ------------------------------------------------------------------------
    // receiver: start bit checked at half a bit, then one sample per bit
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt   <= 16'h0000;
            rx_bit   <= 4'h0;
            rx_busy  <= 1'b0;
            rx_sh    <= 8'h00;
            rx_data  <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (!rx_busy) begin
                if (!rx) begin
                    rx_busy <= 1'b1;
                    rx_cnt  <= {1'b0, divisor[15:1]};
                    rx_bit  <= 4'h0;
                end
            end else if (rx_cnt != 16'h0000) begin
                rx_cnt <= rx_cnt - 16'h0001;
            end else begin
                rx_cnt <= divisor - 16'h0001;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && rx) begin
                    rx_busy <= 1'b0;
                end else if (rx_bit == 4'h9) begin
                    rx_busy  <= 1'b0;
                    rx_valid <= rx;
                    rx_data  <= rx_sh;
                end else if (rx_bit != 4'h0) begin
                    rx_sh <= {rx, rx_sh[7:1]};
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // transmitter: start, eight bits lsb first, stop
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt  <= 16'h0000;
            tx_bit  <= 4'h0;
            tx_sh   <= 10'h3FF;
            tx_busy <= 1'b0;
            tx      <= 1'b1;
        end else if (!tx_busy) begin
            if (tx_start) begin
                tx_busy <= 1'b1;
                tx_sh   <= {1'b1, tx_data, 1'b0};
                tx      <= 1'b0;
                tx_cnt  <= divisor - 16'h0001;
                tx_bit  <= 4'h0;
            end
        end else if (tx_cnt != 16'h0000) begin
            tx_cnt <= tx_cnt - 16'h0001;
        end else if (tx_bit == 4'h9) begin
            tx_busy <= 1'b0;
            tx      <= 1'b1;
        end else begin
            tx_cnt <= divisor - 16'h0001;
            tx_bit <= tx_bit + 4'h1;
            tx_sh  <= {1'b1, tx_sh[9:1]};
            tx     <= tx_sh[1];
        end
    end

endmodule

/* tb/ccm_props.sv */
/* assertions on the pins and actuator outputs of ccm_top.
   assumes a bind onto ccm_top that hands on its reference period. */
`timescale 1ns/1ps
module ccm_props #(
    parameter logic [35:0] REF_PERIOD_CYC = 36'h0C8
) (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic       ZERO_CHECK_INPUT_N,
    input wire logic       SVC_TXD,
    input wire logic       SAMPLE_PUMP,
    input wire logic       ZERO_PUMP,
    input wire logic       SPAN_VALVE,
    input wire logic       SHUTTER,
    input wire logic [1:0] DISP_MSG,
    input wire logic       CAL_LOCK
);
    logic [35:0] ref_cnt;
    logic        ref_seen;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // cycles since the last shutter insertion
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ref_cnt  <= 36'h0;
            ref_seen <= 1'b0;
        end else if ($rose(SHUTTER)) begin
            ref_cnt  <= 36'h1;
            ref_seen <= 1'b1;
        end else begin
            ref_cnt <= ref_cnt + 36'h1;
        end
    end
    sequence s_zero_low; (!ZERO_CHECK_INPUT_N)[*8]; endsequence
    sequence s_zero_held; s_zero_low ##1 s_zero_low; endsequence
    property p_pin_zero; s_zero_held |-> ZERO_PUMP && !SAMPLE_PUMP; endproperty
    property p_zero_excl; ZERO_PUMP |-> !SAMPLE_PUMP; endproperty
    property p_span_excl; SPAN_VALVE |-> !SAMPLE_PUMP; endproperty
    property p_zero_prio; ZERO_PUMP |-> !SPAN_VALVE; endproperty
    property p_disp_zero; ZERO_PUMP |-> DISP_MSG == 2'h1; endproperty
    property p_disp_span; SPAN_VALVE |-> DISP_MSG == 2'h2; endproperty
    property p_lock; CAL_LOCK == !SAMPLE_PUMP; endproperty
    property p_svc_idle; SVC_TXD; endproperty
    property p_shutter; $rose(SHUTTER) && ref_seen |-> ref_cnt == REF_PERIOD_CYC; endproperty
    a_pin_zero: assert property (p_pin_zero) else $error("zero pin held low without zero mode");
    a_zero_excl: assert property (p_zero_excl) else $error("zero pump and sample pump both on");
    a_span_excl: assert property (p_span_excl) else $error("span valve open with sample pump on");
    a_zero_prio: assert property (p_zero_prio) else $error("zero and span modes together");
    a_disp_zero: assert property (p_disp_zero) else $error("zero mode without zero message");
    a_disp_span: assert property (p_disp_span) else $error("span mode without span message");
    a_lock: assert property (p_lock) else $error("calibration lock differs from check mode");
    a_svc_idle: assert property (p_svc_idle) else $error("service port transmitted");
    a_shutter: assert property (p_shutter) else $error("shutter period wrong");
endmodule
bind ccm_top ccm_props #(.REF_PERIOD_CYC(REF_PERIOD_CYC)) u_props (.CLK(CLK), .RST_N(RST_N),
    .ZERO_CHECK_INPUT_N(ZERO_CHECK_INPUT_N), .SVC_TXD(SVC_TXD), .SAMPLE_PUMP(SAMPLE_PUMP),
    .ZERO_PUMP(ZERO_PUMP), .SPAN_VALVE(SPAN_VALVE), .SHUTTER(SHUTTER), .DISP_MSG(DISP_MSG), .CAL_LOCK(CAL_LOCK));

/* tb/ccm_md_master.sv */
/* multidrop master: sends one command frame, collects the reply.
   assumes 8N1 at BIT_CYC clocks per bit, one unit addressed at a time. */
`timescale 1ns/1ps
module ccm_md_master #(
    parameter int BIT_CYC = 16
) (
    input  wire logic clk,
    output logic      txd,
    input  wire logic rxd
);
    logic [7:0] rx_q[$];
    logic [7:0] b;
    initial txd = 1'b1;
    initial forever begin
        @(negedge rxd);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            b[i] = rxd;
        end
        repeat (BIT_CYC) @(posedge clk);
        rx_q.push_back(b);
    end
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            txd <= f[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
    endtask
    // one unit addressed per frame, so replies never collide
    task automatic cmd(input logic [31:0] fld, output logic ok);
        rx_q.delete();
        send(8'h44);
        send(8'h4F);
        for (int i = 3; i >= 0; i--) send(fld[i*8+:8]);
        send(8'h0D);
        for (int n = 0; n < 40 * BIT_CYC && rx_q.size() < 2; n++) @(posedge clk);
        ok = rx_q.size() == 2 && rx_q[0] === 8'h06 && rx_q[1] === 8'h0D;
    endtask
endmodule

/* tb/test_calibration_check_mode_control.sv */
/* self-checking bench for ccm_top: registers, mode pins, serial commands.
   assumes the models in ccm_md_master and the checker bound by ccm_props. */
`timescale 1ns/1ps
module test_calibration_check_mode_control;
    logic        clk, rst_n, psel, penable, pwrite, zero_n, span_n, md_rxd, md_txd, svc_rxd, svc_txd;
    logic        pready, pslverr, err, ok, smp, zp, sv, shutter, lock;
    logic [1:0]  disp;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_count, checked;
    ccm_top #(.DEBOUNCE_CYC(20'h4), .REF_PERIOD_CYC(36'h0C8), .REF_HOLD_CYC(36'h014)) dut (.CLK(clk),
        .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ZERO_CHECK_INPUT_N(zero_n),
        .SPAN_CHECK_INPUT_N(span_n), .MD_RXD(md_rxd), .MD_TXD(md_txd), .SVC_RXD(svc_rxd), .SVC_TXD(svc_txd),
        .SAMPLE_PUMP(smp), .ZERO_PUMP(zp), .SPAN_VALVE(sv), .SHUTTER(shutter), .DISP_MSG(disp), .CAL_LOCK(lock));
    ccm_md_master #(.BIT_CYC(16)) u_md (.clk(clk), .txd(md_rxd), .rxd(md_txd));
    ccm_md_master #(.BIT_CYC(16)) u_svc (.clk(clk), .txd(svc_rxd), .rxd(svc_txd));
    task automatic finish_test;
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, paddr, pwrite, pwdata} <= {1'b1, 1'b0, a, w, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // expected {sample, zero, span, message, lock}
    task automatic mode(input logic [5:0] exp);
        chk({26'h0, smp, zp, sv, disp, lock}, {26'h0, exp});
    endtask
    task automatic pins(input logic z, input logic s);
        @(posedge clk);
        {zero_n, span_n} <= {z, s};
        repeat (16) @(posedge clk);
    endtask
    task automatic t_regs;
        mode(6'h20);
        apb(8'h00, 1'b0, 32'h0); chk(rd, 32'h0);
        apb(8'h04, 1'b0, 32'h0); chk(rd, 32'h65B9);
        apb(8'h04, 1'b1, 32'h10); apb(8'h04, 1'b0, 32'h0); chk(rd, 32'h10);
        apb(8'h10, 1'b0, 32'h0); chk({rd[30:0], err}, 32'h1);
        apb(8'h00, 1'b1, 32'h64); apb(8'h00, 1'b0, 32'h0); chk(rd, 32'h0);
    endtask
    task automatic t_pins;
        pins(1'b0, 1'b1); mode(6'h13);
        pins(1'b1, 1'b1); mode(6'h20);
        pins(1'b1, 1'b0); mode(6'h0D);
        pins(1'b1, 1'b1); mode(6'h20);
        pins(1'b0, 1'b0); mode(6'h13);
        pins(1'b1, 1'b1);
        @(posedge clk) zero_n <= 1'b0;
        repeat (2) @(posedge clk);
        pins(1'b1, 1'b1); mode(6'h20);
    endtask
    task automatic t_serial;
        u_md.cmd("0001", ok); chk(ok, 1'b1); mode(6'h0D);
        u_md.cmd("0000", ok); chk(ok, 1'b1); mode(6'h20);
        u_md.cmd("0011", ok); chk(ok, 1'b1); mode(6'h13);
        u_md.cmd("0010", ok); chk(ok, 1'b1); mode(6'h20);
        u_md.cmd("0511", ok); chk(ok, 1'b0); mode(6'h20);
        u_md.cmd("0021", ok); chk(ok, 1'b0); mode(6'h20);
        apb(8'h00, 1'b1, 32'h2A);
        u_md.cmd("4211", ok); chk(ok, 1'b1); mode(6'h13);
        u_md.cmd("4210", ok); chk(ok, 1'b1); mode(6'h20);
    endtask
    task automatic t_svc;
        u_svc.cmd("4211", ok); chk(ok, 1'b0); mode(6'h20);
        apb(8'h0C, 1'b0, 32'h0); chk(rd, 32'h7);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        finish_test();
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, zero_n, span_n} = {4'h0, 8'h0, 32'h0, 2'b11};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_pins();
        t_serial();
        t_svc();
        finish_test();
    end
endmodule
